/* rtl/sacc_params.svh */
// Timing counts and field positions for the sampling converter control block.
// Assumes a 100 MHz clock; included by the package and the design file.
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH
`define SACC_CLK_PERIOD_NS 10
`define SACC_RESULT_W 14
`define SACC_POWERUP_US 10
`define SACC_POWERUP_CYC ((`SACC_POWERUP_US * 1000) / `SACC_CLK_PERIOD_NS)
`define SACC_CONV_NS 7000
`define SACC_CONV_CYC ((`SACC_CONV_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
`define SACC_HOLD_NS 1000
`define SACC_HOLD_CYC ((`SACC_HOLD_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
`define SACC_MSB 13
`endif

/* rtl/sacc_pkg.sv */
// Types shared by the sampling converter control block.
// Assumes sacc_params.svh is on the include path.
`include "sacc_params.svh"
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_BOOT = 2'b00,
    SACC_IDLE = 2'b01,
    SACC_CONV = 2'b10
  } sacc_state_e;
  // Value and enables of one three-state pin group
  typedef struct packed {
    logic [`SACC_RESULT_W-1:0] out;
    logic [`SACC_RESULT_W-1:0] oe_n;
  } sacc_bus_s;
endpackage

/* rtl/sacc_core.sv */
// Conversion control and parallel result port of a 14-bit sampling converter.
// Assumes all control pins are asynchronous to clk; sample_in is the
// quantised input from the converter core, captured as a conversion starts.
// Functional notes
// - Falling start edge begins a conversion regardless of chip select.
// - Idle: done flag high, sampler tracking.
// - On start, sampler holds and done flag low during conversion.
// - Sampler returns to track mid-conversion, well before next start.
// - Done flag rises at completion; new result reaches the result pins one clock later.
// - Done flag driven only while its enable is low, else high impedance.
// - Result driven only when select and read both low.
// - Whole 14-bit result in one read, MSB at top bit.
// - Strap low gives straight binary, strap high twos complement.
// - Unipolar and bipolar code points follow the coding table.
// - About ten microseconds after reset before conversions start.
`timescale 1ns/1ns
`include "sacc_params.svh"
module sacc_core
  import sacc_pkg::*;
#(
  parameter int POWERUP_CYC = `SACC_POWERUP_CYC,
  parameter int CONV_CYC = `SACC_CONV_CYC,
  parameter int HOLD_CYC = `SACC_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic convert_start_n,
  input wire logic done_flag_output_enable_n,
  input wire logic chip_select_n,
  input wire logic read_enable_n,
  input wire logic offset_mode_strap,
  input wire logic [`SACC_RESULT_W-1:0] sample_in,
  output logic sampler_hold,
  output logic done_flag_out,
  output logic done_flag_oe_n,
  output logic [`SACC_RESULT_W-1:0] result_bits_out,
  output logic [`SACC_RESULT_W-1:0] result_bits_oe_n
);
  // Two-stage synchronisers; only stage two is read by logic
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic start_prev;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      start_prev <= 1'b1;
    end
    else
    begin
      sync1 <= {convert_start_n, done_flag_output_enable_n, chip_select_n, read_enable_n, offset_mode_strap};
      sync2 <= sync1;
      start_prev <= sync2[4];
    end
  end

  logic start_s, flag_en_n_s, cs_n_s, rd_n_s, strap_s, start_fall;
  assign start_s = sync2[4];
  assign flag_en_n_s = sync2[3];
  assign cs_n_s = sync2[2];
  assign rd_n_s = sync2[1];
  assign strap_s = sync2[0];
  assign start_fall = start_prev & ~start_s;

  sacc_state_e state, next_state;
  logic [31:0] count, next_count;
  logic hold, next_hold;
  logic done, next_done;
  logic [`SACC_RESULT_W-1:0] result, next_result;
  // Held sample, so the host may switch channels once busy
  logic [`SACC_RESULT_W-1:0] held, next_held;

  // Conversion sequencer; chip select takes no part in starting
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_hold = hold;
    next_done = done;
    next_result = result;
    next_held = held;
    case (state)
      SACC_BOOT:
      begin
        next_count = count + 32'h1;
        if (count >= 32'(POWERUP_CYC - 1))
        begin
          next_state = SACC_IDLE;
          next_count = 32'h0;
          next_done = 1'b1;
        end
      end
      SACC_IDLE:
      begin
        next_hold = 1'b0;
        next_done = 1'b1;
        if (start_fall)
        begin
          next_state = SACC_CONV;
          next_hold = 1'b1;
          next_done = 1'b0;
          next_count = 32'h0;
          next_held = sample_in;
        end
      end
      SACC_CONV:
      begin
        next_count = count + 32'h1;
        if (count >= 32'(HOLD_CYC - 1))
          next_hold = 1'b0;
        if (count >= 32'(CONV_CYC - 1))
        begin
          next_state = SACC_IDLE;
          next_done = 1'b1;
          next_result = held ^ {strap_s, {(`SACC_RESULT_W-1){1'b0}}};
        end
      end
      default:
      begin
        next_state = SACC_BOOT;
        next_count = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= SACC_BOOT;
      count <= 32'h0;
      hold <= 1'b0;
      done <= 1'b0;
      result <= 14'h0000;
      held <= 14'h0000;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      hold <= next_hold;
      done <= next_done;
      result <= next_result;
      held <= next_held;
    end
  end

  // Registered pin drivers; enables low while driving
  sacc_bus_s bus, next_bus;
  logic next_flag_oe_n;
  always_comb
  begin
    next_flag_oe_n = flag_en_n_s;
    next_bus.out = result;
    next_bus.oe_n = {`SACC_RESULT_W{cs_n_s | rd_n_s}};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus.out <= 14'h0000;
      bus.oe_n <= 14'h3fff;
      done_flag_out <= 1'b0;
      done_flag_oe_n <= 1'b1;
      sampler_hold <= 1'b0;
    end
    else
    begin
      bus <= next_bus;
      done_flag_out <= next_done;
      done_flag_oe_n <= next_flag_oe_n;
      sampler_hold <= next_hold;
    end
  end
  assign result_bits_out = bus.out;
  assign result_bits_oe_n = bus.oe_n;

  a_flag_low_conv: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_CONV) |=> (done_flag_out == 1'b0 || $past(next_state) == SACC_IDLE))
    else $error("done flag high during conversion");
  a_start_begins: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_IDLE && start_fall) |=> (state == SACC_CONV) ##1 (done_flag_out == 1'b0))
    else $error("start edge did not begin conversion");
  a_idle_track: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_IDLE && $past(state) == SACC_IDLE) |-> (!hold && done))
    else $error("idle but holding or flag low");
  a_track_early: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_CONV && count == 32'(CONV_CYC - 1)) |-> !hold)
    else $error("sampler still holding at completion");
  // completion raises flag and loads result
  a_done_result: assert property (@(posedge clk) disable iff (!resetn)
    ($past(state) == SACC_CONV && state == SACC_IDLE) |->
    (done_flag_out && result == ($past(held) ^ {$past(strap_s), {(`SACC_RESULT_W-1){1'b0}}})))
    else $error("completion did not load result");
  a_flag_gate: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (done_flag_oe_n == $past(flag_en_n_s)))
    else $error("flag enable wrong");
  a_result_gate: assert property (@(posedge clk) disable iff (!resetn)
    ($past(cs_n_s) | $past(rd_n_s)) |-> (&result_bits_oe_n))
    else $error("result driven without select and read");
  a_result_hold: assert property (@(posedge clk) disable iff (!resetn)
    !($past(state) == SACC_CONV && state == SACC_IDLE) |-> $stable(result))
    else $error("result changed without completion");
  a_ignore_start: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_CONV && start_fall && count < 32'(CONV_CYC - 1)) |=> (state == SACC_CONV))
    else $error("conversion disturbed by start edge");
  a_boot_wait: assert property (@(posedge clk) disable iff (!resetn)
    (state == SACC_BOOT) |=> (state != SACC_CONV))
    else $error("conversion during power-up");
endmodule

/* verification/sacc_host_model.sv */
// Host-side model: start pulses and read cycles on the converter pins.
// Assumes the bench calls its tasks; pins move 1 ns after a rising edge.
`timescale 1ns/1ns
module sacc_host_model
(
  input wire logic clk,
  output logic convert_start_n,
  output logic chip_select_n,
  output logic read_enable_n
);
  // Idle host: nothing selected, no start
  initial
  begin
    convert_start_n = 1'b1;
    chip_select_n = 1'b1;
    read_enable_n = 1'b1;
  end
  task automatic start_pulse();
    @(posedge clk) #1 convert_start_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 convert_start_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic read_word(input logic with_read);
    @(posedge clk) #1 chip_select_n = 1'b0;
    @(posedge clk) #1 read_enable_n = !with_read;
    repeat (6) @(posedge clk);
    #1 read_enable_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

/* verification/sampling_adc_conversion_control_tb.sv */
// Self-checking bench for the converter control block.
// Assumes short timing parameters; results checked from a queue of notes.
`timescale 1ns/1ns
`include "sacc_params.svh"
module sampling_adc_conversion_control_tb;
  import sacc_pkg::*;
  localparam int CONV = 20;
  logic clk, resetn, flag_en_n, strap, hold, done, done_oe_n, cs_n, rd_n, start_n, was_on;
  logic [`SACC_RESULT_W-1:0] sample;
  sacc_bus_s rbus;
  logic [`SACC_RESULT_W-1:0] exp_q[$];
  logic [`SACC_RESULT_W-1:0] pts[3] = '{14'h0000, 14'h2000, 14'h3fff};
  logic [31:0] rng;
  int error_cnt, tests_run, cycles, low_cnt;

  sacc_host_model host (.clk(clk), .convert_start_n(start_n), .chip_select_n(cs_n), .read_enable_n(rd_n));
  sacc_core #(.POWERUP_CYC(10), .CONV_CYC(CONV), .HOLD_CYC(8)) dut (.clk(clk), .resetn(resetn),
    .convert_start_n(start_n), .done_flag_output_enable_n(flag_en_n), .chip_select_n(cs_n),
    .read_enable_n(rd_n), .offset_mode_strap(strap), .sample_in(sample), .sampler_hold(hold),
    .done_flag_out(done), .done_flag_oe_n(done_oe_n), .result_bits_out(rbus.out),
    .result_bits_oe_n(rbus.oe_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Busy length and first-driven word; the watcher never drives the block
  always @(negedge clk)
  begin
    if (done === 1'b0)
      low_cnt++;
    if (rbus.oe_n === '0 && !was_on)
      check("result word", exp_q.pop_front(), rbus.out);
    was_on = (rbus.oe_n === '0);
  end

  // Hang guard, well above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Extra start mid-run must not stretch the busy time
  task automatic convert(input logic [13:0] s, input logic m);
    int t;
    @(posedge clk) #1 sample = s;
    strap = m;
    low_cnt = 0;
    repeat (2) exp_q.push_back(m ? s ^ 14'h2000 : s);
    host.start_pulse();
    check("busy flag", 14'h0, done);
    check("sampler held", 14'h1, hold);
    sample = ~s;
    @(posedge clk);
    host.start_pulse();
    for (t = 0; t < 100 && done !== 1'b1; t++)
      @(posedge clk) #1;
    check("busy cycles", 14'(CONV), 14'(low_cnt));
    check("sampler tracking", 14'h0, hold);
    host.read_word(1'b0);
    check("select only", 14'h2, 14'(exp_q.size()));
    host.read_word(1'b1);
    host.read_word(1'b1);
    check("repeat reads", 14'h0, 14'(exp_q.size()));
    $display("conversion %h mode %b ended", s, m);
  endtask

  initial
  begin
    resetn = 1'b0;
    flag_en_n = 1'b1;
    strap = 1'b0;
    sample = '0;
    was_on = 1'b0;
    rng = 32'habfb;
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    host.start_pulse();
    repeat (8) @(posedge clk);
    check("flag released", 14'h1, done_oe_n);
    #1 flag_en_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 check("flag driven", 14'h0, done_oe_n);
    check("idle flag", 14'h1, done);
    check("idle sampler", 14'h0, hold);
    $display("reset and flag enable ended");
    for (int i = 0; i < 10; i++)
    begin
      rng = xs(rng);
      convert(i < 6 ? pts[i >> 1] : rng[13:0], i[0]);
    end
    report_and_stop();
  end
endmodule
